// [pkg/cwu_map.svh]
`ifndef CWU_MAP_SVH
`define CWU_MAP_SVH

// Register byte offsets on the Wishbone slave.
`define CWU_OFS_CON0      8'h00
`define CWU_OFS_CON1      8'h04
`define CWU_OFS_DB_RISE   8'h08
`define CWU_OFS_DB_FALL   8'h0c
`define CWU_OFS_CFG       8'h10
`define CWU_OFS_STAT      8'h14

// Control register 0 fields.
`define CWU_BIT_EN        7
`define CWU_BIT_LD        6
`define CWU_MODE_MSB      2
`define CWU_MODE_LSB      0

// Control register 1 fields: polarity in bits 3:0, steering in bits 7:4.
`define CWU_POL_LSB       0
`define CWU_STEER_LSB     4

// Configuration register fields.
`define CWU_SRC_LSB       0
`define CWU_BIT_DBCLK     2
`define CWU_BIT_SD_PIN    3
`define CWU_BIT_RESTART   4
`define CWU_BIT_SHUT      7

// Widths and reset values.
`define CWU_DB_W          6
`define CWU_CON0_RST      8'h00
`define CWU_CON1_RST      8'h00
`define CWU_DB_RST        6'h00
`define CWU_CFG_RST       8'h00

`endif

// [pkg/cwu_pkg.sv]
package cwu_pkg;

    typedef enum logic [2:0] {
        CWU_MODE_STEER_ASYNC = 3'h0,
        CWU_MODE_STEER_SYNC  = 3'h1,
        CWU_MODE_FB_FWD      = 3'h2,
        CWU_MODE_FB_REV      = 3'h3,
        CWU_MODE_HALF        = 3'h4,
        CWU_MODE_PUSH_PULL   = 3'h5,
        CWU_MODE_RSVD6       = 3'h6,
        CWU_MODE_RSVD7       = 3'h7
    } cwu_mode_t;

    typedef enum logic [2:0] {
        CWU_LD_IDLE      = 3'h1,
        CWU_LD_WAIT_FALL = 3'h2,
        CWU_LD_WAIT_RISE = 3'h4
    } cwu_ld_state_t;

    typedef struct packed {
        logic      en;
        logic      ld;
        logic [2:0] rsvd;
        cwu_mode_t mode;
    } cwu_con0_t;

    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } cwu_outs_t;

endpackage

// [src/cwu_unit.sv]
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "cwu_map.svh"
module cwu_unit (
    input  wire logic        clk_i,          // System clock, 200 MHz.
    input  wire logic        rst_i,          // Synchronous reset, active high.
    input  wire logic        wb_cyc_i,       // Wishbone cycle.
    input  wire logic        wb_stb_i,       // Wishbone strobe.
    input  wire logic        wb_we_i,        // Wishbone write enable.
    input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
    output logic             wb_ack_o,       // Wishbone acknowledge.
    output logic [31:0]      wb_dat_o,       // Wishbone read data.
    input  wire logic [3:0]  pulse_src_i,    // Candidate pulse inputs, asynchronous.
    input  wire logic        dbclk_tick_i,   // Alternate dead-band clock, asynchronous.
    input  wire logic        fault_i,        // Fault pin, active high, asynchronous.
    output logic             wave_out_a_o,   // Output A.
    output logic             wave_out_b_o,   // Output B.
    output logic             wave_out_c_o,   // Output C.
    output logic             wave_out_d_o    // Output D.
);

    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
        reg_hit = (adr == ofs);
    endfunction

    // Synchronisers; the first stage feeds only the second.
    logic [3:0] src_meta_reg;
    logic [3:0] src_sync_reg;
    logic       tick_meta_reg;
    logic       tick_sync_reg;
    logic       tick_prev_reg;
    logic       fault_meta_reg;
    logic       fault_sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_meta_reg   <= 4'h0;
            src_sync_reg   <= 4'h0;
            tick_meta_reg  <= 1'b0;
            tick_sync_reg  <= 1'b0;
            tick_prev_reg  <= 1'b0;
            fault_meta_reg <= 1'b0;
            fault_sync_reg <= 1'b0;
        end else begin
            src_meta_reg   <= pulse_src_i;
            src_sync_reg   <= src_meta_reg;
            tick_meta_reg  <= dbclk_tick_i;
            tick_sync_reg  <= tick_meta_reg;
            tick_prev_reg  <= tick_sync_reg;
            fault_meta_reg <= fault_i;
            fault_sync_reg <= fault_meta_reg;
        end
    end

    // Software-visible state.
    logic                  en_reg;
    logic                  ld_reg;
    cwu_pkg::cwu_mode_t    mode_reg;
    logic [3:0]            pol_reg;
    logic [3:0]            steer_reg;
    logic [`CWU_DB_W-1:0]  dbr_buf_reg;
    logic [`CWU_DB_W-1:0]  dbf_buf_reg;
    logic [1:0]            src_sel_reg;
    logic                  dbclk_sel_reg;
    logic                  sd_pin_en_reg;
    logic                  restart_reg;
    logic                  shut_reg;
    logic                  wb_ack_reg;
    logic [31:0]           wb_dat_reg;

    logic                  bus_req;
    logic                  wr_fire;
    logic                  wr_con0;
    logic                  wr_cfg;
    logic                  in_lvl;
    logic                  in_prev_reg;
    logic                  in_rise;
    logic                  in_fall;
    logic                  db_tick;
    logic                  load_now;

    // One pulse input drives everything below.
    assign in_lvl  = src_sync_reg[src_sel_reg];
    assign in_rise = in_lvl & ~in_prev_reg;
    assign in_fall = ~in_lvl & in_prev_reg;
    assign db_tick = dbclk_sel_reg ? (tick_sync_reg & ~tick_prev_reg) : 1'b1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_prev_reg <= 1'b0;
        end else begin
            in_prev_reg <= in_lvl;
        end
    end

    // Bus slave: ack follows a request by one cycle, writes land on the ack edge.
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_we_i & wb_ack_reg & wb_sel_i[0];
    assign wr_con0 = wr_fire & reg_hit(wb_adr_i, `CWU_OFS_CON0);
    assign wr_cfg  = wr_fire & reg_hit(wb_adr_i, `CWU_OFS_CFG);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
        end else begin
            wb_ack_reg <= bus_req & ~wb_ack_reg;
        end
    end

    cwu_pkg::cwu_con0_t con0_view;
    cwu_pkg::cwu_outs_t out_reg;
    cwu_pkg::cwu_ld_state_t ld_state_reg;
    logic [7:0] rd_byte;

    always_comb begin
        con0_view      = `CWU_CON0_RST;
        con0_view.en   = en_reg;
        con0_view.ld   = ld_reg;
        con0_view.mode = mode_reg;
        con0_view.rsvd = 3'h0;
    end

    always_comb begin
        rd_byte = 8'h00;
        if (reg_hit(wb_adr_i, `CWU_OFS_CON0)) begin
            rd_byte = con0_view;
        end else if (reg_hit(wb_adr_i, `CWU_OFS_CON1)) begin
            rd_byte = {steer_reg, pol_reg};
        end else if (reg_hit(wb_adr_i, `CWU_OFS_DB_RISE)) begin
            rd_byte = {2'h0, dbr_buf_reg};
        end else if (reg_hit(wb_adr_i, `CWU_OFS_DB_FALL)) begin
            rd_byte = {2'h0, dbf_buf_reg};
        end else if (reg_hit(wb_adr_i, `CWU_OFS_CFG)) begin
            rd_byte = {shut_reg, 2'h0, restart_reg, sd_pin_en_reg, dbclk_sel_reg, src_sel_reg};
        end else if (reg_hit(wb_adr_i, `CWU_OFS_STAT)) begin
            rd_byte = {out_reg, 1'b0, ~ld_state_reg[0], shut_reg, in_lvl};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_reg <= 32'h0000_0000;
        end else if (bus_req & ~wb_ack_reg) begin
            wb_dat_reg <= {24'h00_0000, rd_byte};
        end
    end

    // Enable and mode; software is expected to move the mode only while disabled.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg   <= 1'b0;
            mode_reg <= cwu_pkg::CWU_MODE_STEER_ASYNC;
        end else if (wr_con0) begin
            en_reg   <= wb_dat_i[`CWU_BIT_EN];
            mode_reg <= cwu_pkg::cwu_mode_t'(wb_dat_i[`CWU_MODE_MSB:`CWU_MODE_LSB]);
        end
    end

    // The set looks at the enable already stored, so a write raising both is refused.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ld_reg <= 1'b0;
        end else if (wr_con0 & wb_dat_i[`CWU_BIT_LD] & en_reg) begin
            ld_reg <= 1'b1;
        end else if (load_now | (wr_con0 & ~wb_dat_i[`CWU_BIT_LD])) begin
            ld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {steer_reg, pol_reg} <= `CWU_CON1_RST;
        end else if (wr_fire & reg_hit(wb_adr_i, `CWU_OFS_CON1)) begin
            pol_reg   <= wb_dat_i[`CWU_POL_LSB+:4];
            steer_reg <= wb_dat_i[`CWU_STEER_LSB+:4];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbr_buf_reg <= `CWU_DB_RST;
            dbf_buf_reg <= `CWU_DB_RST;
        end else begin
            if (wr_fire & reg_hit(wb_adr_i, `CWU_OFS_DB_RISE)) begin
                dbr_buf_reg <= wb_dat_i[`CWU_DB_W-1:0];
            end
            if (wr_fire & reg_hit(wb_adr_i, `CWU_OFS_DB_FALL)) begin
                dbf_buf_reg <= wb_dat_i[`CWU_DB_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_sel_reg   <= 2'h0;
            dbclk_sel_reg <= 1'b0;
            sd_pin_en_reg <= 1'b0;
            restart_reg   <= 1'b0;
        end else if (wr_cfg) begin
            src_sel_reg   <= wb_dat_i[`CWU_SRC_LSB+:2];
            dbclk_sel_reg <= wb_dat_i[`CWU_BIT_DBCLK];
            sd_pin_en_reg <= wb_dat_i[`CWU_BIT_SD_PIN];
            restart_reg   <= wb_dat_i[`CWU_BIT_RESTART];
        end
    end

    // Shutdown: a fault or a software set wins over any clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shut_reg <= 1'b0;
        end else if ((sd_pin_en_reg & fault_sync_reg) | (wr_cfg & wb_dat_i[`CWU_BIT_SHUT])) begin
            shut_reg <= 1'b1;
        end else if ((wr_cfg & ~wb_dat_i[`CWU_BIT_SHUT]) | (restart_reg & in_rise)) begin
            shut_reg <= 1'b0;
        end
    end

    // Buffer load sequence: arm, wait for a fall, load on the following rise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ld_state_reg <= cwu_pkg::CWU_LD_IDLE;
        end else if (~ld_reg) begin
            ld_state_reg <= cwu_pkg::CWU_LD_IDLE;
        end else begin
            unique case (ld_state_reg)
                cwu_pkg::CWU_LD_IDLE: begin
                    ld_state_reg <= cwu_pkg::CWU_LD_WAIT_FALL;
                end
                cwu_pkg::CWU_LD_WAIT_FALL: begin
                    if (in_fall) begin
                        ld_state_reg <= cwu_pkg::CWU_LD_WAIT_RISE;
                    end
                end
                cwu_pkg::CWU_LD_WAIT_RISE: begin
                    if (in_rise) begin
                        ld_state_reg <= cwu_pkg::CWU_LD_IDLE;
                    end
                end
            endcase
        end
    end

    assign load_now = ld_reg & (ld_state_reg == cwu_pkg::CWU_LD_WAIT_RISE) & in_rise;

    // Working counts; while disabled they follow the buffers so the first run is right.
    logic [`CWU_DB_W-1:0] dbr_act_reg;
    logic [`CWU_DB_W-1:0] dbf_act_reg;
    logic [`CWU_DB_W-1:0] rise_load;
    logic [`CWU_DB_W-1:0] fall_load;
    logic [`CWU_DB_W-1:0] rise_cnt_reg;
    logic [`CWU_DB_W-1:0] fall_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbr_act_reg <= `CWU_DB_RST;
            dbf_act_reg <= `CWU_DB_RST;
        end else if (~en_reg | load_now) begin
            dbr_act_reg <= dbr_buf_reg;
            dbf_act_reg <= dbf_buf_reg;
        end
    end

    assign rise_load = load_now ? dbr_buf_reg : dbr_act_reg;
    assign fall_load = load_now ? dbf_buf_reg : dbf_act_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_cnt_reg <= `CWU_DB_RST;
        end else if (in_rise) begin
            rise_cnt_reg <= rise_load;
        end else if (db_tick && rise_cnt_reg != `CWU_DB_RST) begin
            rise_cnt_reg <= rise_cnt_reg - 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fall_cnt_reg <= `CWU_DB_RST;
        end else if (in_fall) begin
            fall_cnt_reg <= fall_load;
        end else if (db_tick && fall_cnt_reg != `CWU_DB_RST) begin
            fall_cnt_reg <= fall_cnt_reg - 6'h01;
        end
    end

    // A side turns on only once its count has run out; the other side is already off.
    logic a_core;
    logic b_core;
    assign a_core = in_lvl & ~in_rise & (rise_cnt_reg == `CWU_DB_RST);
    assign b_core = ~in_lvl & ~in_fall & (fall_cnt_reg == `CWU_DB_RST);

    // Push-pull phase and steering latch.
    logic       pp_phase_reg;
    logic [3:0] steer_act_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pp_phase_reg <= 1'b0;
        end else if (in_rise) begin
            pp_phase_reg <= ~pp_phase_reg;
        end
    end

    // Synchronous steering only takes new selections at an input rise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            steer_act_reg <= 4'h0;
        end else if (mode_reg != cwu_pkg::CWU_MODE_STEER_SYNC || in_rise) begin
            steer_act_reg <= steer_reg;
        end
    end

    cwu_pkg::cwu_outs_t raw;

    always_comb begin
        raw = 4'h0;
        unique case (mode_reg)
            cwu_pkg::CWU_MODE_HALF: begin
                raw.a = a_core;
                raw.b = b_core;
                raw.c = a_core;
                raw.d = b_core;
            end
            cwu_pkg::CWU_MODE_PUSH_PULL: begin
                raw.a = a_core & pp_phase_reg;
                raw.b = a_core & ~pp_phase_reg;
                raw.c = raw.a;
                raw.d = raw.b;
            end
            cwu_pkg::CWU_MODE_STEER_ASYNC, cwu_pkg::CWU_MODE_STEER_SYNC: begin
                raw = steer_act_reg & {4{a_core}};
            end
            cwu_pkg::CWU_MODE_FB_FWD: begin
                raw.a = 1'b1;
                raw.d = a_core;
            end
            cwu_pkg::CWU_MODE_FB_REV: begin
                raw.c = 1'b1;
                raw.b = a_core;
            end
            default: begin
                raw = 4'h0;
            end
        endcase
    end

    // Inactive level after polarity equals the polarity bit itself.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    out_reg[gi] <= 1'b0;
                end else begin
                    out_reg[gi] <= (raw[gi] & en_reg & ~shut_reg) ^ pol_reg[gi];
                end
            end
        end
    endgenerate

    assign wb_ack_o     = wb_ack_reg;
    assign wb_dat_o     = wb_dat_reg;
    assign wave_out_a_o = out_reg.a;
    assign wave_out_b_o = out_reg.b;
    assign wave_out_c_o = out_reg.c;
    assign wave_out_d_o = out_reg.d;

    default clocking cb_main @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [3:0] act_now;
    assign act_now = out_reg ^ pol_reg;

    sequence s_rd_con0;
        bus_req && !wb_we_i && !wb_ack_reg && reg_hit(wb_adr_i, `CWU_OFS_CON0);
    endsequence

    property p_rsvd_zero;
        s_rd_con0 |=> wb_ack_o && wb_dat_o[5:3] == 3'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

    property p_ld_needs_en;
        wr_con0 && wb_dat_i[`CWU_BIT_LD] && !en_reg && !ld_reg |=> !ld_reg;
    endproperty
    a_ld_needs_en: assert property (p_ld_needs_en) else $error("load set while off");

    property p_ld_clears;
        load_now && !(wr_con0 && wb_dat_i[`CWU_BIT_LD])
            |=> !ld_reg && dbr_act_reg == $past(dbr_buf_reg);
    endproperty
    a_ld_clears: assert property (p_ld_clears) else $error("load did not complete");

    property p_act_hold;
        en_reg && !load_now
            |=> dbr_act_reg == $past(dbr_act_reg) && dbf_act_reg == $past(dbf_act_reg);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("counts changed without load");

    property p_no_overlap;
        mode_reg == cwu_pkg::CWU_MODE_HALF && $stable(pol_reg) |-> !(act_now[0] && act_now[1]);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("A and B both active");

    property p_mirror;
        mode_reg == cwu_pkg::CWU_MODE_HALF && $stable(mode_reg) && $stable(pol_reg)
            |-> act_now[2] == act_now[0] && act_now[3] == act_now[1];
    endproperty
    a_mirror: assert property (p_mirror) else $error("C or D differ from A or B");

    property p_shutdown;
        shut_reg |=> out_reg == $past(pol_reg);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("drive during shutdown");

    property p_disabled;
        !en_reg |=> out_reg == $past(pol_reg);
    endproperty
    a_disabled: assert property (p_disabled) else $error("drive while disabled");

    property p_cnt_dec;
        !in_rise && !dbclk_sel_reg && rise_cnt_reg != 6'h00
            |=> rise_cnt_reg == $past(rise_cnt_reg) - 6'h01;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) else $error("rise count not stepping");

    // Checked at the pin, so a broken turn-on path is caught and not only the term.
    property p_hold_off;
        mode_reg == cwu_pkg::CWU_MODE_HALF && rise_cnt_reg != 6'h00
            |=> out_reg.a == $past(pol_reg[0]);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("A on before dead band");

endmodule

// [tb/cwu_gate_model.sv]
`timescale 1ns/1ps
// Gate-driver pair at the far side: it counts shoot-through on the primary leg
// and reports a desaturation fault back after one cycle or, when slow, four.
module cwu_gate_model (
    input  wire logic               clk_i,        // System clock.
    input  wire logic               rst_i,        // Synchronous reset, active high.
    input  wire cwu_pkg::cwu_outs_t outs_i,       // Gate commands A to D.
    input  wire logic               fault_req_i,  // Bench asks for a fault report.
    input  wire logic               slow_i,       // Report after four cycles.
    output logic                    fault_o,      // Fault line to the generator.
    output logic [15:0]             overlap_o     // Cycles with A and B both on.
);
    logic [3:0] fault_sh_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_sh_reg <= 4'h0;
        end else begin
            fault_sh_reg <= {fault_sh_reg[2:0], fault_req_i};
        end
    end

    assign fault_o = slow_i ? fault_sh_reg[3] : fault_sh_reg[0];

    // Both switches of one leg on together would short the supply rail.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overlap_o <= 16'h0000;
        end else if (outs_i.a && outs_i.b) begin
            overlap_o <= overlap_o + 16'h0001;
        end
    end
endmodule

// [tb/cwu_unit_bench.sv]
`timescale 1ns/1ps
`include "cwu_map.svh"
module cwu_unit_bench;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               wb_cyc = 1'b0;
    logic               wb_stb = 1'b0;
    logic               wb_we = 1'b0;
    logic [7:0]         wb_adr = 8'h00;
    logic [31:0]        wb_dat = 32'h0;
    logic [3:0]         wb_sel = 4'h0;
    logic               wb_ack;
    logic [31:0]        wb_rdat;
    logic [3:0]         src = 4'h0;
    logic               dbclk = 1'b0;
    logic               fault;
    logic               fault_req = 1'b0;
    logic               slow = 1'b0;
    logic [15:0]        overlap;
    wire cwu_pkg::cwu_outs_t outs;
    logic [7:0]         rd;
    int                 seed = 60633;
    int                 mismatches = 0;
    int                 n_checks = 0;

    always #2.5 clk_i = ~clk_i;

    cwu_unit u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
        .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat), .pulse_src_i(src), .dbclk_tick_i(dbclk),
        .fault_i(fault), .wave_out_a_o(outs.a), .wave_out_b_o(outs.b),
        .wave_out_c_o(outs.c), .wave_out_d_o(outs.d)
    );

    cwu_gate_model u_gate (
        .clk_i(clk_i), .rst_i(rst_i), .outs_i(outs), .fault_req_i(fault_req),
        .slow_i(slow), .fault_o(fault), .overlap_o(overlap)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until ack is sampled; the bench checks that ack is seen on the second clock.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                      input logic [3:0] sel);
        int i;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= {24'h0, dat};
        wb_sel <= sel;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack !== 1'b1);
        chk(8'(i), 8'h02);
        rd = wb_rdat[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    // Noise on the unselected sources shows that only source 0 is used.
    task automatic settle(input logic level);
        @(posedge clk_i);
        src <= {3'($random(seed)), level};
        repeat (80) @(negedge clk_i);
    endtask

    // Dead time is the gap between one output leaving and the other arriving.
    task automatic measure(input int n, input int m, input logic [3:0] pol);
        int e, i, t_off, t_on, bad;
        bad = 0;
        for (e = 0; e < 2; e++) begin
            @(posedge clk_i);
            src <= {3'($random(seed)), e == 0};
            t_off = -1;
            t_on = -1;
            for (i = 0; i < 150; i++) begin
                @(negedge clk_i);
                if (t_off < 0 && ((e == 0) ? outs.b : outs.a) === 1'b0) t_off = i;
                if (t_on < 0 && ((e == 0) ? outs.a : outs.b) === 1'b1) t_on = i;
                if ({outs.c, outs.d} !== {outs.a ^ pol[2], outs.b ^ pol[3]}) bad++;
            end
            // The count is loaded in the edge cycle itself, so the gap is one clock longer.
            chk(8'(t_on - t_off), (e == 0) ? 8'(n + 1) : 8'(m + 1));
        end
        chk(8'(bad), 8'h00);
    endtask

    function automatic logic [3:0] exp_outs(input logic [2:0] md);
        case (md)
            3'h0, 3'h1, 3'h4: exp_outs = 4'h5;
            3'h2: exp_outs = 4'h9;
            3'h3: exp_outs = 4'h6;
            default: exp_outs = 4'h0;
        endcase
    endfunction

    initial begin
        int k, n, m, n1;
        logic [3:0] pol;
        logic [2:0] md;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `CWU_OFS_CON0, 8'h00, 4'h1);
        chk(rd, 8'h00);
        wb(1'b1, 8'hfc, 8'h55, 4'h1);
        wb(1'b0, 8'hfc, 8'h00, 4'h1);
        chk(rd, 8'h00);
        wb(1'b1, `CWU_OFS_CON0, 8'h3f, 4'h1);
        wb(1'b0, `CWU_OFS_CON0, 8'h00, 4'h1);
        chk(rd, 8'h07);
        wb(1'b1, `CWU_OFS_CON0, 8'h86, 4'he);
        wb(1'b0, `CWU_OFS_CON0, 8'h00, 4'h1);
        chk(rd, 8'h07);
        wb(1'b1, `CWU_OFS_CON0, 8'hc4, 4'h1);
        wb(1'b0, `CWU_OFS_CON0, 8'h00, 4'h1);
        chk(rd, 8'h84);
        for (k = 0; k < 5; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 63 : {$random(seed)} % 64;
            m = (k == 0) ? 63 : (k == 1) ? 0 : {$random(seed)} % 64;
            pol = {2'($random(seed)), 2'b00};
            wb(1'b1, `CWU_OFS_CON0, 8'h04, 4'h1);
            wb(1'b1, `CWU_OFS_DB_RISE, 8'(n), 4'h1);
            wb(1'b1, `CWU_OFS_DB_FALL, 8'(m), 4'h1);
            wb(1'b1, `CWU_OFS_CON1, {4'($random(seed)), pol}, 4'h1);
            wb(1'b1, `CWU_OFS_CON0, 8'h84, 4'h1);
            settle(1'b0);
            measure(n, m, pol);
        end
        for (k = 0; k < 2; k++) begin
            slow <= k[0];
            wb(1'b1, `CWU_OFS_CFG, {3'h0, k[0], 4'h8}, 4'h1);
            settle(1'b1);
            @(posedge clk_i);
            fault_req <= 1'b1;
            repeat (10) @(negedge clk_i);
            chk(8'(outs), 8'(pol));
            @(posedge clk_i);
            fault_req <= 1'b0;
            repeat (10) @(negedge clk_i);
            // Only the pass with auto-restart may leave shutdown on the next input rise.
            settle(1'b0);
            settle(1'b1);
            chk({7'h0, outs.a}, {7'h0, k[0]});
            wb(1'b1, `CWU_OFS_CFG, 8'h00, 4'h1);
        end
        n1 = (n + 5) % 64;
        wb(1'b1, `CWU_OFS_DB_RISE, 8'(n1), 4'h1);
        settle(1'b0);
        measure(n, m, pol);
        wb(1'b1, `CWU_OFS_CON0, 8'hc4, 4'h1);
        wb(1'b0, `CWU_OFS_CON0, 8'h00, 4'h1);
        chk(rd, 8'hc4);
        measure(n, m, pol);
        measure(n1, m, pol);
        wb(1'b0, `CWU_OFS_CON0, 8'h00, 4'h1);
        chk(rd, 8'h84);
        // Selected dead-band clock: a count of three needs three ticks before A turns on.
        wb(1'b1, `CWU_OFS_CON0, 8'h04, 4'h1);
        wb(1'b1, `CWU_OFS_DB_RISE, 8'h03, 4'h1);
        wb(1'b1, `CWU_OFS_CFG, 8'h04, 4'h1);
        wb(1'b1, `CWU_OFS_CON0, 8'h84, 4'h1);
        settle(1'b0);
        settle(1'b1);
        for (k = 0; k < 6; k++) begin
            if (k == 4) begin
                @(negedge clk_i);
                chk({7'h0, outs.a}, 8'h00);
            end
            repeat (4) @(posedge clk_i);
            dbclk <= ~dbclk;
        end
        repeat (8) @(negedge clk_i);
        chk({7'h0, outs.a}, 8'h01);
        wb(1'b1, `CWU_OFS_CFG, 8'h00, 4'h1);
        wb(1'b1, `CWU_OFS_CON0, 8'h04, 4'h1);
        wb(1'b1, `CWU_OFS_DB_RISE, 8'h00, 4'h1);
        wb(1'b1, `CWU_OFS_DB_FALL, 8'h00, 4'h1);
        wb(1'b1, `CWU_OFS_CON1, 8'h50, 4'h1);
        for (k = 0; k < 8; k++) begin
            md = 3'(k);
            wb(1'b1, `CWU_OFS_CON0, {5'h00, md}, 4'h1);
            wb(1'b1, `CWU_OFS_CON0, {5'h10, md}, 4'h1);
            settle(1'b0);
            settle(1'b1);
            if (md == 3'h5) begin
                chk({7'h0, outs.a ^ outs.b}, 8'h01);
                chk(8'({outs.c, outs.d}), 8'({outs.a, outs.b}));
            end else begin
                chk(8'(outs), 8'(exp_outs(md)));
            end
            wb(1'b1, `CWU_OFS_CON0, {5'h00, md}, 4'h1);
            repeat (3) @(negedge clk_i);
            chk(8'(outs), 8'h00);
        end
        chk({7'h0, |overlap}, 8'h00);
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
endmodule
